// ===== rtl/phy_led_strap_pins.sv
// shared col/crs strap pins and programmable link led pin
`timescale 1ns/10ps
`default_nettype none
module phy_led_strap_pins
  import strap_led_pkg::*;
#(
  parameter int SETTLE_CYC = STRAP_SETTLE_CYC,
  parameter int HALF_CYC   = BLINK_HALF_CYC
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               clk_en,
  input  wire logic               col_in,
  input  wire logic               crs_in,
  input  wire logic               col_pin_i,
  input  wire logic               crs_pin_i,
  input  wire logic               led_pin_i,
  input  wire logic               fiber_select,
  input  wire logic               link_up,
  input  wire logic               activity,
  input  wire logic               led_mode_we,
  input  wire logic [1:0]         led_mode_wdata,
  input  wire logic [1:0]         speed_led_mode_wdata,
  input  wire logic [BLINK_W-1:0] blink_half_period,
  output logic                    col_pin_o,
  output logic                    col_pin_oe,
  output logic                    crs_pin_o,
  output logic                    crs_pin_oe,
  output logic                    link_led_out,
  output logic                    link_led_oe,
  output logic                    strap_cfg_bit_a,
  output logic                    strap_cfg_bit_b,
  output logic                    autoneg_enable_strap,
  output logic                    strap_done,
  output logic [1:0]              led_mode,
  output logic [1:0]              speed_led_mode
);
  // ***************************************************************
  // strap sampling sequence
  // ***************************************************************
  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_RUN    = 2'b10
  } strap_state_e;

  strap_state_e       state_ff;
  strap_state_e       nxt_state;
  logic [7:0]         settle_ff;
  logic               settle_end;
  logic               sample_now;
  logic               running;
  logic               nxt_autoneg;
  logic               nxt_led;
  logic               act_prev_ff;
  logic               act_pulse;
  logic               blink_trig;
  logic               blink_on;
  logic               blink_phase;

  assign settle_end = (settle_ff == 8'(SETTLE_CYC - 1));
  assign sample_now = (state_ff == ST_SAMPLE);
  assign running    = (state_ff == ST_RUN);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_SETTLE: if (settle_end) nxt_state = ST_SAMPLE;
      ST_SAMPLE: nxt_state = ST_RUN;
      ST_RUN:    nxt_state = ST_RUN;
      default:   nxt_state = ST_SETTLE;
    endcase
  end

  // fiber forces autoneg off
  assign nxt_autoneg = fiber_select ? 1'b0 : led_pin_i;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff  <= ST_SETTLE;
      settle_ff <= 8'h00;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      if (!settle_end) begin
        settle_ff <= settle_ff + 8'h01;
      end
    end
  end

  // straps captured once, after reset has released and pins settled
  always_ff @(posedge core_clk) begin
    if (rst) begin
      strap_cfg_bit_a      <= 1'b0;
      strap_cfg_bit_b      <= 1'b0;
      autoneg_enable_strap <= 1'b0;
      strap_done           <= 1'b0;
    end else if (clk_en && sample_now) begin
      strap_cfg_bit_a      <= col_pin_i;
      strap_cfg_bit_b      <= crs_pin_i;
      autoneg_enable_strap <= nxt_autoneg;
      strap_done           <= 1'b1;
    end
  end

  // ***************************************************************
  // mii status pins
  // ***************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      col_pin_o  <= 1'b0;
      col_pin_oe <= 1'b0;
      crs_pin_o  <= 1'b0;
      crs_pin_oe <= 1'b0;
    end else if (clk_en) begin
      col_pin_oe <= running;
      crs_pin_oe <= running;
      col_pin_o  <= running & col_in;
      crs_pin_o  <= running & crs_in;
    end
  end

  // ***************************************************************
  // led mode fields
  // ***************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      led_mode       <= LED_MODE_RST;
      speed_led_mode <= LED_MODE_RST;
    end else if (clk_en && led_mode_we) begin
      led_mode       <= led_mode_wdata;
      speed_led_mode <= speed_led_mode_wdata;
    end
  end

  // ***************************************************************
  // link led
  // ***************************************************************
  assign act_pulse  = activity & ~act_prev_ff;
  // only link/activity mode with link up may start a blink
  assign blink_trig = act_pulse & link_up & (led_mode == LED_MODE_LINK_ACT);

  led_blinker #(
    .HALF_CYC    (HALF_CYC)
  ) u_blink (
    .core_clk    (core_clk),
    .rst         (rst),
    .clk_en      (clk_en),
    .act_pulse   (blink_trig),
    .half_period (blink_half_period),
    .blink_on    (blink_on),
    .blink_phase (blink_phase)
  );

  // pin is low for on; blink flips to high in its off phase
  always_comb begin
    nxt_led = 1'b1;
    unique case (led_mode)
      LED_MODE_LINK_ACT: nxt_led = ~link_up | (blink_on & ~blink_phase);
      LED_MODE_LINK:     nxt_led = ~link_up;
      LED_MODE_RSVD_A:   nxt_led = 1'b1;
      LED_MODE_RSVD_B:   nxt_led = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      act_prev_ff  <= 1'b0;
      link_led_out <= 1'b1;
      link_led_oe  <= 1'b0;
    end else if (clk_en) begin
      act_prev_ff  <= activity;
      link_led_oe  <= running;
      link_led_out <= running ? nxt_led : 1'b1;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  a_pins_undriven: assert property (@(posedge core_clk) disable iff (rst)
    !running |=> !col_pin_oe && !crs_pin_oe && !link_led_oe)
    else $error("shared pin driven before strap sampling");
  a_col_follows: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && running |=> col_pin_o == $past(col_in))
    else $error("collision pin does not follow mac collision");
  a_crs_follows: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && running |=> crs_pin_o == $past(crs_in))
    else $error("carrier pin does not follow carrier sense");
  a_strap_a_cap: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && sample_now |=> strap_cfg_bit_a == $past(col_pin_i) && strap_done)
    else $error("first strap bit not captured");
  a_strap_b_cap: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && sample_now |=> strap_cfg_bit_b == $past(crs_pin_i))
    else $error("second strap bit not captured");
  a_autoneg_copper: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && sample_now && !fiber_select |=> autoneg_enable_strap == $past(led_pin_i))
    else $error("autoneg strap wrong in copper mode");
  a_autoneg_fiber: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && sample_now && fiber_select |=> !autoneg_enable_strap)
    else $error("autoneg enabled in fiber mode");
  a_link_only: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && running && led_mode == LED_MODE_LINK |=> link_led_out == !$past(link_up))
    else $error("link-only led level wrong");
  a_no_link_off: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && running && !link_up |=> link_led_out)
    else $error("led on without link");
  a_mode_write: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && led_mode_we |=> led_mode == $past(led_mode_wdata))
    else $error("led mode write lost");

  c_strap_done:  cover property (@(posedge core_clk) disable iff (rst) $rose(strap_done));
  c_fiber_strap: cover property (@(posedge core_clk) disable iff (rst)
    sample_now && fiber_select && led_pin_i);
  c_blinking:    cover property (@(posedge core_clk) disable iff (rst)
    running && link_up && blink_on && !link_led_out ##1 link_led_out);
endmodule : phy_led_strap_pins
`default_nettype wire

// ===== rtl/strap_led_pkg.sv
// constants for the shared strap pins and the link led logic
package strap_led_pkg;
  // ***************************************************************
  // led mode field in the led control register
  // ***************************************************************
  localparam logic [4:0] LED_CTRL_REG      = 5'h1E;
  localparam int         LED_LINK_MODE_HI  = 1;
  localparam int         LED_LINK_MODE_LO  = 0;
  localparam int         LED_SPEED_MODE_HI = 15;
  localparam int         LED_SPEED_MODE_LO = 14;
  localparam logic [1:0] LED_MODE_LINK_ACT = 2'h0;
  localparam logic [1:0] LED_MODE_LINK     = 2'h1;
  localparam logic [1:0] LED_MODE_RSVD_A   = 2'h2;
  localparam logic [1:0] LED_MODE_RSVD_B   = 2'h3;
  localparam logic [1:0] LED_MODE_RST      = 2'h0;
  // ***************************************************************
  // control register bit fed by the strap
  // ***************************************************************
  localparam logic [4:0] BASIC_CTRL_REG    = 5'h00;
  localparam int         AUTONEG_EN_BIT    = 12;
  // ***************************************************************
  // strap sampling and blink timing
  // ***************************************************************
  localparam int         CLK_PERIOD_NS     = 20;
  localparam int         STRAP_SETTLE_NS   = 100;
  localparam int         STRAP_SETTLE_CYC  = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         BLINK_HALF_MS     = 50;
  localparam int         BLINK_HALF_CYC    = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int         BLINK_W           = 24;
endpackage : strap_led_pkg

// ===== rtl/led_blinker.sv
// activity blink generator for the link led
`timescale 1ns/10ps
`default_nettype none
module led_blinker
  import strap_led_pkg::*;
#(
  parameter int HALF_CYC = BLINK_HALF_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic act_pulse,
  input  wire logic [BLINK_W-1:0] half_period,
  output logic      blink_on,
  output logic      blink_phase
);
  logic [BLINK_W-1:0] cnt_ff;
  logic [BLINK_W-1:0] nxt_cnt;
  logic               run_ff;
  logic               phase_ff;
  logic               wrap;
  logic               extend_ff;

  assign wrap        = run_ff && (cnt_ff == '0);
  assign nxt_cnt     = wrap ? half_period : cnt_ff - 1'b1;
  assign blink_on    = run_ff;
  assign blink_phase = phase_ff;

  // activity seen during a running blink keeps it running one more period; several events in one period give only one
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_ff    <= '0;
      run_ff    <= 1'b0;
      phase_ff  <= 1'b0;
      extend_ff <= 1'b0;
    end else if (clk_en) begin
      if (!run_ff) begin
        if (act_pulse) begin
          run_ff    <= 1'b1;
          cnt_ff    <= half_period;
          phase_ff  <= 1'b1;
          extend_ff <= 1'b0;
        end
      end else begin
        cnt_ff <= nxt_cnt;
        if (act_pulse) begin
          extend_ff <= 1'b1;
        end
        if (wrap) begin
          phase_ff <= ~phase_ff;
          if (!phase_ff) begin
            if (extend_ff || act_pulse) begin
              extend_ff <= 1'b0;
            end else begin
              run_ff <= 1'b0;
            end
          end
        end
      end
    end
  end

  a_blink_starts: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !run_ff && act_pulse |=> run_ff && phase_ff)
    else $error("blink did not start on activity");
endmodule : led_blinker
`default_nettype wire

// ===== verification/board_model.sv
// board side of the shared pins: strap pulls, mac inputs and led pad
`timescale 1ns/10ps
`default_nettype none
module board_model (
  input  wire logic col_strap,
  input  wire logic crs_strap,
  input  wire logic led_strap,
  input  wire logic col_o,
  input  wire logic col_oe,
  input  wire logic crs_o,
  input  wire logic crs_oe,
  input  wire logic led_o,
  input  wire logic led_oe,
  output logic      col_pad,
  output logic      crs_pad,
  output logic      led_pad
);
  // undriven pads settle to their pull resistor level
  assign col_pad = col_oe ? col_o : col_strap;
  assign crs_pad = crs_oe ? crs_o : crs_strap;
  assign led_pad = led_oe ? led_o : led_strap;
endmodule : board_model
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the shared strap pins and link led
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import strap_led_pkg::*;
  logic core_clk = 0, rst = 1, col_in = 0, crs_in = 0, fiber_select = 0;
  logic link_up = 0, activity = 0, led_mode_we = 0, clk_en = 1;
  logic col_strap = 0, crs_strap = 0, led_strap = 1;
  logic [1:0] led_mode_wdata = 2'h0, speed_led_mode_wdata = 2'h0;
  logic [1:0] led_mode, speed_led_mode;
  logic [BLINK_W-1:0] half = 24'h000002;
  logic col_o, col_oe, crs_o, crs_oe, led_o, led_oe, col_pad, crs_pad, led_pad;
  logic cfg_a, cfg_b, an_en, strap_done;
  int fail_count = 0, n_tests = 0, cycles = 0;
  always #10 core_clk = ~core_clk;
  phy_led_strap_pins #(.SETTLE_CYC(5), .HALF_CYC(3)) phy_led_strap_pins_inst (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .col_in(col_in), .crs_in(crs_in),
    .col_pin_i(col_pad), .crs_pin_i(crs_pad), .led_pin_i(led_pad),
    .fiber_select(fiber_select), .link_up(link_up), .activity(activity),
    .led_mode_we(led_mode_we), .led_mode_wdata(led_mode_wdata),
    .speed_led_mode_wdata(speed_led_mode_wdata), .blink_half_period(half),
    .col_pin_o(col_o), .col_pin_oe(col_oe), .crs_pin_o(crs_o), .crs_pin_oe(crs_oe),
    .link_led_out(led_o), .link_led_oe(led_oe), .strap_cfg_bit_a(cfg_a),
    .strap_cfg_bit_b(cfg_b), .autoneg_enable_strap(an_en), .strap_done(strap_done),
    .led_mode(led_mode), .speed_led_mode(speed_led_mode));
  board_model board_model_inst (
    .col_strap(col_strap), .crs_strap(crs_strap), .led_strap(led_strap),
    .col_o(col_o), .col_oe(col_oe), .crs_o(crs_o), .crs_oe(crs_oe),
    .led_o(led_o), .led_oe(led_oe),
    .col_pad(col_pad), .crs_pad(crs_pad), .led_pad(led_pad));
  // ***************************************************************
  // shared helpers
  // ***************************************************************
  task automatic conclude;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [1:0] got, input logic [1:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s", $time, msg);
      fail_count++;
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      conclude();
    end
  end
  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_strap(input logic a, input logic b, input logic l, input logic f);
    int k;
    col_strap = a;
    crs_strap = b;
    led_strap = l;
    fiber_select = f;
    rst = 1;
    tick(2);
    chk(col_oe, 1'b0, "col driven in reset");
    rst = 0;
    k = 0;
    while (strap_done !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    chk(strap_done, 1'b1, "strap done");
    chk({col_oe, crs_oe}, 2'h0, "pins driven before sample");
    chk(cfg_a, a, "strap bit a");
    chk(cfg_b, b, "strap bit b");
    chk(an_en, l & ~f, "autoneg strap");
    tick(1);
    chk({col_oe, crs_oe}, 2'h3, "mii pins not driven");
    chk(led_oe, 1'b1, "led not driven");
  endtask : t_strap
  task automatic t_mii;
    col_in = 1;
    crs_in = 0;
    tick(1);
    chk({col_pad, crs_pad}, 2'h2, "col high");
    col_in = 0;
    crs_in = 1;
    tick(1);
    chk({col_pad, crs_pad}, 2'h1, "crs high");
    crs_in = 0;
  endtask : t_mii
  task automatic set_mode(input logic [1:0] m);
    led_mode_we = 1;
    led_mode_wdata = m;
    speed_led_mode_wdata = ~m;
    tick(1);
    led_mode_we = 0;
    tick(2);
    chk(led_mode, m, "led mode field");
    chk(speed_led_mode, ~m, "speed mode field");
  endtask : set_mode
  task automatic t_link(input logic [1:0] m);
    set_mode(m);
    link_up = 0;
    tick(2);
    chk(led_pad, 1'b1, "no link level");
    link_up = 1;
    tick(2);
    chk(led_pad, (m[1] ? 1'b1 : 1'b0), "link level");
  endtask : t_link
  task automatic t_act(input logic [1:0] m);
    int hi;
    t_link(m);
    activity = 1;
    tick(1);
    activity = 0;
    hi = 0;
    repeat (14) begin
      tick(1);
      if (led_pad === 1'b1) hi++;
    end
    chk(hi > 0, m == LED_MODE_LINK_ACT, "blink seen");
    chk(hi < 14, 1'b1, "led stuck off");
    chk(hi == (m == LED_MODE_LINK_ACT ? int'(half) + 1 : 0), 1'b1, "blink length");
    tick(40);
    chk(led_pad, 1'b0, "link level after blink");
  endtask : t_act
  task automatic t_freeze;
    clk_en = 0;
    col_in = 1;
    link_up = 1;
    tick(3);
    chk({col_pad, led_pad}, 2'h1, "state moved while disabled");
    clk_en = 1;
    tick(1);
    chk({col_pad, led_pad}, 2'h2, "state stuck after enable");
    col_in = 0;
    link_up = 0;
    tick(1);
  endtask : t_freeze
  task automatic t_extend;
    int hi;
    activity = 1;
    tick(1);
    activity = 0;
    tick(1);
    activity = 1;
    tick(1);
    activity = 0;
    hi = 0;
    repeat (20) begin
      tick(1);
      if (led_pad === 1'b1) hi++;
    end
    chk(hi == 2 * (int'(half) + 1), 1'b1, "blink not extended");
  endtask : t_extend
  initial begin
    t_strap(1, 0, 1, 0);
    t_strap(0, 1, 1, 1);
    t_strap(1, 1, 0, 0);
    t_mii();
    t_freeze();
    t_act(LED_MODE_LINK);
    t_act(LED_MODE_LINK_ACT);
    t_extend();
    t_link(LED_MODE_RSVD_A);
    t_link(LED_MODE_RSVD_B);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
